//--- core/dds_tuning_word_control.sv
`timescale 1ns/1ps
// Functional notes
// RL1 - tuning word top bit forced zero; only 31 low bits come from outside
// RL2 - load source select high: parallel word taken on update strobe rising edge
// RL3 - update strobe is resynchronised to the system clock; phase stays continuous
// RL4 - load source select low: parallel word taken on every system clock
// RL5 - clear low zeroes tuning word, buffer, accumulator, sine path, outputs asynchronously
// RL6 - during power-down parallel inputs are ignored and nothing new is loaded
// RL7 - after clear, outputs stay all zero until a tuning word is loaded
// RL8 - serial port works only while serial select is low; select is static
// RL9 - one serial bit shifted per shift clock rising edge while window high
// RL10 - host sends exactly 31 bits msb first; top bit is internal zero
// RL11 - host holds window high for whole 31-bit sequence, then drops it
// RL12 - after window drops, next update strobe rising edge commits buffer to word
// RL13 - previous buffered word leaves on serial output msb first while shifting
// RL14 - serial buffer shifts during power-down; strobe after wake commits it
// RL15 - phase bypass drives top 14 accumulator bits out, sine table idle
// RL16 - in bypass, coding has no effect; all other controls act unchanged
// RL17 - output bits 12 and 13 only used in bypass; static otherwise
// RL18 - sleep low enters power-down; sleep is synchronised to system clock
// RL19 - power-down keeps all registers and freezes output; wake continues phase
// RL20 - clear still works during power-down
// RL21 - after clear release word accepted at once; outputs zero until pipeline fills
// RL22 - tuning word added to accumulator every system clock
// RL23 - normal mode maps phase through sine table to amplitude
// RL24 - accumulator wraps modulo full width on overflow

module dds_tuning_word_control (
	// clock and resets
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic clear_n_in,
	// mode pins
	input wire logic load_source_select_in,
	input wire logic serial_select_n_in,
	input wire logic sleep_n_in,
	input wire logic phase_bypass_enable_in,
	input wire logic update_strobe_in,
	// parallel tuning port
	input wire logic [30:0] tuning_word_in,
	// serial tuning port
	input wire logic shift_clock_in,
	input wire logic shift_window_in,
	input wire logic serial_word_in,
	output logic serial_word_out,
	// waveform and status
	output logic [13:0] waveform_out,
	output logic asleep_out,
	output logic word_loaded_out
);

	typedef struct packed {
		logic [1:0] clear_sync;
		logic [dds_pkg::CTL_WIDTH-1:0] ctl_meta;
		logic [dds_pkg::CTL_WIDTH-1:0] ctl_sync;
		logic [dds_pkg::EXT_WIDTH-1:0] par_meta;
		logic [dds_pkg::EXT_WIDTH-1:0] par_sync;
		logic strobe_prev;
		logic shift_clock_prev;
		dds_pkg::ser_state_type ser_state;
		logic [dds_pkg::EXT_WIDTH-1:0] shift_buf;
		logic ser_out;
		logic [dds_pkg::TUNING_WIDTH-1:0] tuning;
		logic loaded;
		logic [dds_pkg::TUNING_WIDTH-1:0] phase;
		logic [dds_pkg::WAVE_WIDTH-1:0] stage;
		logic stage_valid;
		logic [dds_pkg::WAVE_WIDTH-1:0] wave;
		logic asleep;
	} state_type;

	state_type state;
	state_type next_state;

	// quarter-wave magnitude, 11 bits, sampled at half-step offsets
	function automatic logic [10:0] quarter_sine(input logic [3:0] index);
		logic [10:0] mag;
		mag = 11'h000;
		case (index)
			4'h0: mag = 11'h064;
			4'h1: mag = 11'h12c;
			4'h2: mag = 11'h1f1;
			4'h3: mag = 11'h2b2;
			4'h4: mag = 11'h36b;
			4'h5: mag = 11'h41c;
			4'h6: mag = 11'h4c3;
			4'h7: mag = 11'h55f;
			4'h8: mag = 11'h5ed;
			4'h9: mag = 11'h66c;
			4'ha: mag = 11'h6dc;
			4'hb: mag = 11'h73b;
			4'hc: mag = 11'h787;
			4'hd: mag = 11'h7c2;
			4'he: mag = 11'h7e9;
			4'hf: mag = 11'h7fd;
			default: mag = 11'h000;
		endcase
		return mag;
	endfunction

	// full-wave amplitude in offset binary from the top phase bits
	function automatic logic [11:0] sine_amplitude(input logic [5:0] top);
		logic [3:0] index;
		logic [11:0] mag;
		index = top[4] ? ~top[3:0] : top[3:0];
		mag = {1'b0, quarter_sine(index)};
		return top[5] ? 12'(dds_pkg::AMP_MID - mag) : 12'(dds_pkg::AMP_MID + mag);
	endfunction

	// word of either port, top bit forced zero
	function automatic logic [31:0] widen_word(input logic [30:0] word);
		return {1'b0, word};
	endfunction

	logic clear_active;
	logic awake;
	logic serial_mode;
	logic strobe_rise;
	logic shift_rise;
	logic window;
	logic [dds_pkg::EXT_WIDTH-1:0] shifted_buf;

	always_comb begin
		clear_active = !state.clear_sync[1];
		awake = state.ctl_sync[dds_pkg::CTL_SLEEP_N];
		serial_mode = !state.ctl_sync[dds_pkg::CTL_SERIAL_SEL_N];
		strobe_rise = state.ctl_sync[dds_pkg::CTL_STROBE] && !state.strobe_prev;
		shift_rise = state.ctl_sync[dds_pkg::CTL_SHIFT_CLK] && !state.shift_clock_prev;
		window = state.ctl_sync[dds_pkg::CTL_WINDOW];
		shifted_buf = {state.shift_buf[dds_pkg::EXT_WIDTH-2:0], state.ctl_sync[dds_pkg::CTL_SER_DATA]};
	end

	always_comb begin
		next_state = state;

		// pin synchronisers, two flops each
		next_state.clear_sync = {state.clear_sync[0], 1'b1};
		next_state.ctl_meta = {serial_word_in, shift_window_in, shift_clock_in, update_strobe_in,
			phase_bypass_enable_in, sleep_n_in, serial_select_n_in, load_source_select_in};
		next_state.ctl_sync = state.ctl_meta;
		next_state.par_meta = tuning_word_in;
		next_state.par_sync = state.par_meta;
		next_state.strobe_prev = state.ctl_sync[dds_pkg::CTL_STROBE]; // [RL3]
		next_state.shift_clock_prev = state.ctl_sync[dds_pkg::CTL_SHIFT_CLK];
		next_state.asleep = !awake; // [RL18]

		if (clear_active) begin
			// hold zero until clear release passes the sync
			next_state.ser_state = dds_pkg::ser_idle;
			next_state.shift_buf = '0; // [RL5]
			next_state.ser_out = 1'b0;
			next_state.tuning = dds_pkg::TUNING_RESET; // [RL5]
			next_state.loaded = 1'b0; // [RL7]
			next_state.phase = dds_pkg::PHASE_RESET;
			next_state.stage = dds_pkg::WAVE_RESET;
			next_state.stage_valid = 1'b0;
			next_state.wave = dds_pkg::WAVE_RESET; // [RL5] [RL20]
		end else begin
			// serial port, runs asleep or awake
			if (serial_mode) begin // [RL8] [RL14]
				case (state.ser_state)
					dds_pkg::ser_idle: begin
						if (shift_rise && window) begin
							next_state.shift_buf = shifted_buf; // [RL9]
							next_state.ser_state = dds_pkg::ser_shifting;
						end
					end
					dds_pkg::ser_shifting: begin
						if (!window) begin
							next_state.ser_state = dds_pkg::ser_armed; // [RL11]
						end else if (shift_rise) begin
							next_state.shift_buf = shifted_buf; // [RL9] [RL10]
						end
					end
					dds_pkg::ser_armed: begin
						if (shift_rise && window) begin
							next_state.shift_buf = shifted_buf;
							next_state.ser_state = dds_pkg::ser_shifting;
						end else if (strobe_rise && awake) begin
							next_state.tuning = widen_word(state.shift_buf); // [RL12] [RL14] [RL1]
							next_state.loaded = 1'b1;
							next_state.ser_state = dds_pkg::ser_idle;
						end
					end
					default: begin
						next_state.ser_state = dds_pkg::ser_idle;
					end
				endcase
			end else begin
				next_state.ser_state = dds_pkg::ser_idle;
				// parallel port, ignored while asleep
				if (awake) begin // [RL6]
					if (state.ctl_sync[dds_pkg::CTL_LOAD_SEL]) begin
						if (strobe_rise) begin
							next_state.tuning = widen_word(state.par_sync); // [RL2] [RL1]
							next_state.loaded = 1'b1;
						end
					end else begin
						next_state.tuning = widen_word(state.par_sync); // [RL4] [RL1]
						next_state.loaded = 1'b1;
					end
				end
			end
			// msb of the held word leads on the daisy-chain output
			next_state.ser_out = next_state.shift_buf[dds_pkg::EXT_WIDTH-1]; // [RL13]

			// accumulator and output pipeline freeze while asleep
			if (awake) begin // [RL19]
				next_state.phase = 32'(state.phase + state.tuning); // [RL22] [RL24]
				if (state.ctl_sync[dds_pkg::CTL_BYPASS]) begin
					next_state.stage = state.phase[dds_pkg::PHASE_TOP:dds_pkg::PHASE_BYPASS_LOW]; // [RL15] [RL16]
				end else begin
					// bits 12 and 13 held low outside bypass
					next_state.stage = {2'b00,
						sine_amplitude(state.phase[dds_pkg::PHASE_TOP:dds_pkg::LUT_ADDR_LOW])}; // [RL23] [RL17]
				end
				next_state.stage_valid = state.loaded; // [RL21]
				next_state.wave = state.stage_valid ? state.stage : dds_pkg::WAVE_RESET; // [RL7] [RL21]
			end
		end
	end

	always_ff @(posedge clk_in or negedge clear_n_in) begin
		if (!clear_n_in) begin
			state <= '0; // [RL5] [RL20]
		end else if (!reset_n_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	always_comb begin
		waveform_out = state.wave;
		serial_word_out = state.ser_out;
		asleep_out = state.asleep;
		word_loaded_out = state.loaded;
	end

endmodule

//--- shared/dds_pkg.sv
package dds_pkg;

	// accumulator and tuning word
	localparam int TUNING_WIDTH = 32;
	localparam int EXT_WIDTH = 31;
	localparam logic [31:0] TUNING_RESET = 32'h0000_0000;
	localparam logic [31:0] PHASE_RESET = 32'h0000_0000;

	// output path
	localparam int WAVE_WIDTH = 14;
	localparam int AMP_WIDTH = 12;
	localparam int PHASE_TOP = 31;
	localparam int PHASE_BYPASS_LOW = 18;
	localparam int LUT_ADDR_LOW = 26;
	localparam logic [11:0] AMP_MID = 12'h800;
	localparam logic [13:0] WAVE_RESET = 14'h0000;
	localparam int PIPE_LATENCY = 2;

	// control pin sync vector layout
	localparam int CTL_WIDTH = 8;
	localparam int CTL_LOAD_SEL = 0;
	localparam int CTL_SERIAL_SEL_N = 1;
	localparam int CTL_SLEEP_N = 2;
	localparam int CTL_BYPASS = 3;
	localparam int CTL_STROBE = 4;
	localparam int CTL_SHIFT_CLK = 5;
	localparam int CTL_WINDOW = 6;
	localparam int CTL_SER_DATA = 7;
	localparam logic [7:0] CTL_RESET = 8'h00;

	// timing
	localparam int CLOCK_HZ = 10000000;
	localparam int SHIFT_CLOCK_PERIOD_NS = 800;

	// serial port states
	typedef enum logic [1:0] {
		ser_idle,
		ser_shifting,
		ser_armed
	} ser_state_type;

endpackage

//--- verification/dds_props.sv
`timescale 1ns/1ps
module dds_props (
	// clock and controls
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic clear_n_in,
	input wire logic load_source_select_in,
	input wire logic serial_select_n_in,
	input wire logic sleep_n_in,
	input wire logic phase_bypass_enable_in,
	// outputs
	input wire logic serial_word_out,
	input wire logic [13:0] waveform_out,
	input wire logic asleep_out,
	input wire logic word_loaded_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_slept; !sleep_n_in [*6]; endsequence
	sequence s_woken; sleep_n_in [*6]; endsequence
	a_clear_zeroes: assert property (!clear_n_in |-> waveform_out == 14'h0000 && !word_loaded_out)
		else $error("outputs live in clear");
	a_unloaded_zero: assert property (!word_loaded_out |-> waveform_out == 14'h0000)
		else $error("output before load");
	a_sleep_enter: assert property (disable iff (!reset_n_in || !clear_n_in) s_slept |-> asleep_out)
		else $error("sleep not entered");
	a_sleep_leave: assert property (disable iff (!reset_n_in || !clear_n_in) s_woken |-> !asleep_out)
		else $error("sleep not left");
	a_output_frozen: assert property (disable iff (!reset_n_in || !clear_n_in)
		$past(asleep_out, 2) && $past(asleep_out) && asleep_out |-> $stable(waveform_out))
		else $error("output moved asleep");
	a_top_bits_idle: assert property (!phase_bypass_enable_in [*6] |-> waveform_out[13:12] == 2'b00)
		else $error("top bits active");
	a_chain_quiet: assert property (disable iff (!reset_n_in || !clear_n_in)
		serial_select_n_in [*6] |=> $stable(serial_word_out))
		else $error("serial port active");
	a_load_at_once: assert property ($rose(clear_n_in) && !load_source_select_in && serial_select_n_in
		&& sleep_n_in |-> ##[1:10] word_loaded_out)
		else $error("no load after clear");
endmodule
bind dds_tuning_word_control dds_props i_dds_props (.clk_in(clk_in), .reset_n_in(reset_n_in),
	.clear_n_in(clear_n_in), .load_source_select_in(load_source_select_in),
	.serial_select_n_in(serial_select_n_in), .sleep_n_in(sleep_n_in),
	.phase_bypass_enable_in(phase_bypass_enable_in), .serial_word_out(serial_word_out),
	.waveform_out(waveform_out), .asleep_out(asleep_out), .word_loaded_out(word_loaded_out));

//--- verification/dds_serial_host.sv
`timescale 1ns/1ps
module dds_serial_host (
	// frame control
	input wire logic start_in,
	input wire logic [30:0] word_in,
	input wire logic chain_in,
	// serial pins and result
	output logic shift_clock_out = 1'b0,
	output logic shift_window_out = 1'b0,
	output logic serial_data_out = 1'b0,
	output logic done_out = 1'b0,
	output logic [30:0] chained_out = 31'h00000000
);
	always @(posedge start_in) begin
		done_out = 1'b0;
		#130;
		shift_window_out = 1'b1;
		for (int i = 30; i >= 0; i--) begin
			serial_data_out = word_in[i];
			#400 shift_clock_out = 1'b1;
			chained_out[i] = chain_in;
			#400 shift_clock_out = 1'b0;
		end
		#400 shift_window_out = 1'b0;
		serial_data_out = ~serial_data_out;
		done_out = 1'b1;
	end
endmodule

//--- verification/dds_tuning_word_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("mismatch %0t %h %h", $time, g, e); end end
module dds_tuning_word_control_tb_top;
	logic clk_in = 1'b0, reset_n_in = 1'b0, clear_n_in = 1'b0, load_source_select_in = 1'b0;
	logic serial_select_n_in = 1'b1, sleep_n_in = 1'b1, phase_bypass_enable_in = 1'b1, update_strobe_in = 1'b0;
	logic [30:0] tuning_word_in = 31'h00040000, frame_word = 31'h00000000, chained;
	logic shift_clock_in, shift_window_in, serial_word_in, serial_word_out, asleep_out, word_loaded_out;
	logic [13:0] waveform_out;
	logic start = 1'b0, done;
	int fail_count = 0, n_checks = 0;
	dds_tuning_word_control i_dds_tuning_word_control (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.clear_n_in(clear_n_in), .load_source_select_in(load_source_select_in),
		.serial_select_n_in(serial_select_n_in), .sleep_n_in(sleep_n_in),
		.phase_bypass_enable_in(phase_bypass_enable_in), .update_strobe_in(update_strobe_in),
		.tuning_word_in(tuning_word_in), .shift_clock_in(shift_clock_in), .shift_window_in(shift_window_in),
		.serial_word_in(serial_word_in), .serial_word_out(serial_word_out), .waveform_out(waveform_out),
		.asleep_out(asleep_out), .word_loaded_out(word_loaded_out));
	dds_serial_host i_dds_serial_host (.start_in(start), .word_in(frame_word), .chain_in(serial_word_out),
		.shift_clock_out(shift_clock_in), .shift_window_out(shift_window_in),
		.serial_data_out(serial_word_in), .done_out(done), .chained_out(chained));
	initial begin
		forever #50 clk_in = ~clk_in;
	end
	task automatic cycles(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	function automatic logic [13:0] step_of(input logic [30:0] w);
		return {1'b0, w[30:18]};
	endfunction
	// phase advance per clock, seen through bypass
	task automatic check_step(input logic [13:0] e);
		logic [13:0] a;
		cycles(1);
		#1;
		a = waveform_out;
		cycles(1);
		#1;
		`CHK(waveform_out - a, e)
	endtask
	task automatic strobe();
		update_strobe_in <= 1'b1;
		cycles(4);
		update_strobe_in <= 1'b0;
		cycles(4);
	endtask
	task automatic send_frame(input logic [30:0] w, input logic [30:0] prev);
		frame_word <= w;
		start <= 1'b1;
		cycles(2);
		start <= 1'b0;
		for (int k = 0; k < 400; k++) begin
			if (done === 1'b1) break;
			cycles(1);
		end
		`CHK(chained, prev)
		cycles(6);
	endtask
	task automatic t_parallel();
		check_step(step_of(31'h00040000));
		tuning_word_in <= 31'h7ffc0000;
		cycles(8);
		check_step(step_of(31'h7ffc0000));
		phase_bypass_enable_in <= 1'b0;
		cycles(8);
		#1;
		`CHK(waveform_out[13:12], 2'b00)
		cycles(1);
		phase_bypass_enable_in <= 1'b1;
		load_source_select_in <= 1'b1;
		tuning_word_in <= 31'h00080000;
		cycles(8);
		check_step(step_of(31'h7ffc0000));
		strobe();
		check_step(step_of(31'h00080000));
		sleep_n_in <= 1'b0;
		cycles(8);
		check_step(14'h0000);
		`CHK(asleep_out, 1'b1)
		tuning_word_in <= 31'h00100000;
		strobe();
		sleep_n_in <= 1'b1;
		cycles(8);
		check_step(step_of(31'h00080000));
	endtask
	task automatic t_serial();
		serial_select_n_in <= 1'b0;
		cycles(6);
		send_frame(31'h000c0000, 31'h00000000);
		check_step(step_of(31'h00080000));
		strobe();
		check_step(step_of(31'h000c0000));
		sleep_n_in <= 1'b0;
		cycles(6);
		send_frame(31'h4abc0000, 31'h000c0000);
		strobe();
		sleep_n_in <= 1'b1;
		cycles(8);
		check_step(step_of(31'h000c0000));
		strobe();
		check_step(step_of(31'h4abc0000));
	endtask
	task automatic t_clear();
		sleep_n_in <= 1'b0;
		cycles(6);
		clear_n_in <= 1'b0;
		// parallel port, loading every clock, once clear lifts
		serial_select_n_in <= 1'b1;
		load_source_select_in <= 1'b0;
		cycles(2);
		#1;
		`CHK(waveform_out, 14'h0000)
		`CHK(word_loaded_out, 1'b0)
		cycles(1);
		clear_n_in <= 1'b1;
		sleep_n_in <= 1'b1;
		cycles(1);
		#1;
		`CHK(waveform_out, 14'h0000)
		`CHK(word_loaded_out, 1'b0)
		cycles(11);
		#1;
		`CHK(word_loaded_out, 1'b1)
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		fail_count++;
		results();
	end
	initial begin
		cycles(6);
		reset_n_in <= 1'b1;
		cycles(2);
		clear_n_in <= 1'b1;
		cycles(12);
		t_parallel();
		t_serial();
		t_clear();
		results();
	end
endmodule
